// *** rtl/sst_tracker.sv ***
// Per-socket connection state tracker with its byte register port.
// Assumes packet engines on the same clock deliver one-cycle segment strobes.
//
// Notes on behaviour
// - State code is read-only, eight bits, and resets to released.
// - Close, or a timeout in any TCP state but TCP-opened, ends in released; graceful disconnect follows the rule below.
// - Open with TCP protocol gives the TCP-opened code.
// - Awaiting peer waits for SYN; timeout flags and releases.
// - Connected reached via accepted SYN or successful connect; transfers allowed.
// - Peer FIN gives half-closed; transfers still allowed; disconnect or close follow.
// - Open with UDP protocol gives datagram code, no handshake.
// - Raw frame mode only on socket zero; open gives raw code.
// - Connect shows request-sent; SYN/ACK connects; timeout flags and releases.
// - Received SYN shows request-received; reply success connects; timeout releases.
// - Finishing, shutting and linger codes end released on completion or timeout.
// - Final-ack wait ends released on FIN/ACK, or timeout with flag.
// - State changes only on host commands, received control segments, engine results, expiry or linger end.
// - Source port high byte at lower offset, low byte next.
// - Peer RST releases the socket in any TCP state; datagram and raw ignore it.
// - Graceful disconnect from connected or half-closed sends FIN first; finishing, shutting, linger and final-ack wait ignore it; others release at once.
// - Close command releases immediately with no exchange.
// - Connect event flag rises once on entering connected.
`timescale 1ns/1ps
module sst_tracker
  import sst_pkg::*;
#(
  parameter int SOCKET_ID = 0,
  parameter int LINGER_CYCLES = LINGER_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Received control segments and engine results
  input wire logic rx_syn,
  input wire logic rx_synack,
  input wire logic rx_fin,
  input wire logic rx_finack,
  input wire logic rx_rst,
  input wire logic synack_done,
  input wire logic tcp_retry_expiry,
  // Requests to the transmit engine
  output logic tx_syn,
  output logic tx_synack,
  output logic tx_fin,
  // Socket status
  output logic [7:0] socket_state,
  output logic [15:0] source_port,
  output logic transfer_allowed,
  output logic [EVT_WIDTH-1:0] socket_event_flags
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (LINGER_CYCLES < 1 || LINGER_CYCLES > 65536)
  begin : g_bad_linger
    $error("LINGER_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  sst_state_type state_q;
  sst_state_type state_d;
  logic [7:0] mode_q;
  logic [15:0] port_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [15:0] linger_q;
  logic [15:0] linger_d;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [EVT_WIDTH-1:0] evt_clr;
  logic tx_syn_d;
  logic tx_synack_d;
  logic tx_fin_d;

  wire cmd_wr = reg_wr_en && (reg_addr == OFF_COMMAND);
  wire cmd_open = cmd_wr && (reg_wdata == CMD_OPEN);
  wire cmd_listen = cmd_wr && (reg_wdata == CMD_LISTEN);
  wire cmd_connect = cmd_wr && (reg_wdata == CMD_CONNECT);
  wire cmd_graceful = cmd_wr && (reg_wdata == CMD_GRACEFUL);
  wire cmd_close = cmd_wr && (reg_wdata == CMD_CLOSE);
  wire [3:0] proto = mode_q[PROTO_LSB +: 4];
  wire raw_allowed = (SOCKET_ID == 0);
  wire linger_end = (linger_q == 16'(LINGER_CYCLES - 1));
  wire tcp_live = (state_q != ST_RELEASED) && (state_q != ST_DATAGRAM)
    && (state_q != ST_RAW_FRAMES);

  // Send and receive-done need no state move; they only count while transfers run
  assign transfer_allowed = (state_q == ST_CONNECTED) || (state_q == ST_HALF_CLOSED)
    || (state_q == ST_DATAGRAM) || (state_q == ST_RAW_FRAMES);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Priority: close, peer reset, expiry, graceful disconnect, then normal flow
  always_comb
  begin
    state_d = state_q;
    tx_syn_d = 1'b0;
    tx_synack_d = 1'b0;
    tx_fin_d = 1'b0;
    evt_set = '0;
    if (cmd_close)
      state_d = ST_RELEASED;
    else if (rx_rst && tcp_live)
      state_d = ST_RELEASED;
    else if (tcp_retry_expiry && tcp_live && state_q != ST_TCP_OPENED)
    begin
      state_d = ST_RELEASED;
      evt_set[EVT_TIMEOUT] = 1'b1;
    end
    else if (cmd_graceful)
    begin
      if (state_q == ST_CONNECTED)
      begin
        state_d = ST_FINISHING;
        tx_fin_d = 1'b1;
      end
      else if (state_q == ST_HALF_CLOSED)
      begin
        state_d = ST_FINAL_ACK_WAIT;
        tx_fin_d = 1'b1;
      end
      else if (!(state_q inside {ST_FINISHING, ST_SHUTTING, ST_LINGER, ST_FINAL_ACK_WAIT}))
        state_d = ST_RELEASED;
    end
    else
    begin
      case (state_q)
        ST_RELEASED:
          if (cmd_open)
          begin
            if (proto == PROTO_TCP)
              state_d = ST_TCP_OPENED;
            else if (proto == PROTO_UDP)
              state_d = ST_DATAGRAM;
            else if (proto == PROTO_RAW && raw_allowed)
              state_d = ST_RAW_FRAMES;
          end
        ST_TCP_OPENED:
          if (cmd_listen)
            state_d = ST_AWAITING_PEER;
          else if (cmd_connect)
          begin
            state_d = ST_REQUEST_SENT;
            tx_syn_d = 1'b1;
          end
        ST_AWAITING_PEER:
          if (rx_syn)
          begin
            state_d = ST_REQUEST_RECEIVED;
            tx_synack_d = 1'b1;
          end
        ST_REQUEST_RECEIVED:
          if (synack_done)
            state_d = ST_CONNECTED;
        ST_REQUEST_SENT:
          if (rx_synack)
            state_d = ST_CONNECTED;
        ST_CONNECTED:
          if (rx_fin)
            state_d = ST_HALF_CLOSED;
        ST_FINISHING:
          if (rx_finack)
            state_d = ST_LINGER;
          else if (rx_fin)
            state_d = ST_SHUTTING;
        ST_SHUTTING:
          if (rx_finack)
            state_d = ST_LINGER;
        ST_LINGER:
          if (linger_end)
            state_d = ST_RELEASED;
        ST_FINAL_ACK_WAIT:
          if (rx_finack)
            state_d = ST_RELEASED;
        ST_HALF_CLOSED, ST_DATAGRAM, ST_RAW_FRAMES:
          state_d = state_q;
        default:
          state_d = ST_RELEASED;
      endcase
    end
    evt_set[EVT_CONNECT] = (state_d == ST_CONNECTED) && (state_q != ST_CONNECTED);
    evt_set[EVT_DISCONNECT] = (rx_fin || rx_finack) && tcp_live;
  end

  assign evt_clr = (reg_wr_en && reg_addr == OFF_EVENTS) ? reg_wdata[EVT_WIDTH-1:0] : '0;
  assign linger_d = (state_q == ST_LINGER && !linger_end) ? linger_q + 16'h0001 : 16'h0000;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // State is one register, so a read never sees half an update
  always_comb
  begin
    case (reg_addr)
      OFF_MODE: rdata_d = mode_q;
      OFF_EVENTS: rdata_d = {{(8 - EVT_WIDTH){1'b0}}, socket_event_flags};
      OFF_STATE: rdata_d = state_q;
      OFF_PORT_HI: rdata_d = port_q[15:8];
      OFF_PORT_LO: rdata_d = port_q[7:0];
      default: rdata_d = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_RELEASED;
      linger_q <= 16'h0000;
      tx_syn <= 1'b0;
      tx_synack <= 1'b0;
      tx_fin <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      linger_q <= linger_d;
      tx_syn <= tx_syn_d;
      tx_synack <= tx_synack_d;
      tx_fin <= tx_fin_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q <= RST_MODE;
      port_q <= RST_PORT;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (reg_wr_en && reg_addr == OFF_MODE)
        mode_q <= reg_wdata;
      if (reg_wr_en && reg_addr == OFF_PORT_HI)
        port_q[15:8] <= reg_wdata;
      if (reg_wr_en && reg_addr == OFF_PORT_LO)
        port_q[7:0] <= reg_wdata;
      if (reg_rd_en)
        rdata_q <= rdata_d;
    end
  end

  sst_flag_bits #(
    .WIDTH(EVT_WIDTH)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .set_bits(evt_set),
    .clr_bits(evt_clr),
    .flags_q(socket_event_flags)
  );

  assign reg_rdata = rdata_q;
  assign socket_state = state_q;
  assign source_port = port_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_RESET_RELEASED: assert property (@(posedge clk) rst |=> state_q == ST_RELEASED)
    else $error("State not released after reset");
  AST_CLOSE_RELEASES: assert property (@(posedge clk) disable iff (rst)
    cmd_close |=> state_q == ST_RELEASED && !tx_fin)
    else $error("Close did not release at once");
  AST_OPEN_TCP: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_RELEASED && cmd_open && proto == PROTO_TCP) |=> state_q == ST_TCP_OPENED)
    else $error("TCP open missed");
  AST_OPEN_UDP: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_RELEASED && cmd_open && proto == PROTO_UDP) |=> state_q == ST_DATAGRAM)
    else $error("UDP open missed");
  AST_RAW_SOCKET_ZERO: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_RAW_FRAMES |-> SOCKET_ID == 0)
    else $error("Raw frame state on nonzero socket");
  AST_CONNECT_SYN: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_TCP_OPENED && cmd_connect && !rx_rst)
    |=> state_q == ST_REQUEST_SENT && tx_syn ##1 !tx_syn)
    else $error("Connect did not send SYN");
  AST_TIMEOUT_FLAG: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_FINAL_ACK_WAIT && tcp_retry_expiry && !cmd_close && !rx_rst)
    |=> state_q == ST_RELEASED && socket_event_flags[EVT_TIMEOUT])
    else $error("Timeout did not flag and release");
  AST_PEER_RESET: assert property (@(posedge clk) disable iff (rst)
    (rx_rst && state_q == ST_CONNECTED) |=> state_q == ST_RELEASED)
    else $error("Peer reset ignored");
  AST_CONNECT_FLAG: assert property (@(posedge clk) disable iff (rst)
    (state_q != ST_CONNECTED ##1 state_q == ST_CONNECTED) |-> socket_event_flags[EVT_CONNECT])
    else $error("Connect flag not raised");
  AST_PORT_HIGH_BYTE: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == OFF_PORT_HI) |=> source_port[15:8] == $past(reg_wdata))
    else $error("Port high byte not stored");
  AST_LINGER_BOUND: assert property (@(posedge clk) disable iff (rst)
    linger_q <= 16'(LINGER_CYCLES - 1))
    else $error("Linger count overran");

  COV_SERVER: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_AWAITING_PEER ##[1:50] state_q == ST_CONNECTED);
  COV_CLIENT: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_REQUEST_SENT ##[1:50] state_q == ST_CONNECTED);
  COV_PASSIVE: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_FINAL_ACK_WAIT ##[1:50] state_q == ST_RELEASED);

endmodule // sst_tracker

// *** rtl/sst_pkg.sv ***
// Constants, register map and state codes of the socket state tracker.
// Assumes a byte-wide register port with the offsets below.
package sst_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COMMAND = 8'h01;
  localparam logic [7:0] OFF_EVENTS = 8'h02;
  localparam logic [7:0] OFF_STATE = 8'h03;
  localparam logic [7:0] OFF_PORT_HI = 8'h04;
  localparam logic [7:0] OFF_PORT_LO = 8'h05;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_PORT = 16'h0000;
  localparam logic [7:0] RST_EVENTS = 8'h00;

  // ---------------------------------------------------------------
  // Commands and protocol patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_LISTEN = 8'h02;
  localparam logic [7:0] CMD_CONNECT = 8'h04;
  localparam logic [7:0] CMD_GRACEFUL = 8'h08;
  localparam logic [7:0] CMD_CLOSE = 8'h10;
  localparam logic [7:0] CMD_SEND = 8'h20;
  localparam logic [7:0] CMD_RECEIVE_DONE_CMD_DONE = 8'h40;
  localparam logic [3:0] PROTO_TCP = 4'h1;
  localparam logic [3:0] PROTO_UDP = 4'h2;
  localparam logic [3:0] PROTO_RAW = 4'h4;
  localparam int PROTO_LSB = 0;

  // ---------------------------------------------------------------
  // Event flag bit positions
  // ---------------------------------------------------------------
  localparam int EVT_CONNECT = 0;
  localparam int EVT_DISCONNECT = 1;
  localparam int EVT_TIMEOUT = 3;
  localparam int EVT_WIDTH = 5;

  // ---------------------------------------------------------------
  // Linger timing
  // ---------------------------------------------------------------
  localparam int LINGER_CYCLES_DEF = 256;

  // ---------------------------------------------------------------
  // State codes
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_RELEASED = 8'h00,
    ST_TCP_OPENED = 8'h13,
    ST_AWAITING_PEER = 8'h14,
    ST_REQUEST_SENT = 8'h15,
    ST_REQUEST_RECEIVED = 8'h16,
    ST_CONNECTED = 8'h17,
    ST_FINISHING = 8'h18,
    ST_SHUTTING = 8'h1A,
    ST_LINGER = 8'h1B,
    ST_HALF_CLOSED = 8'h1C,
    ST_FINAL_ACK_WAIT = 8'h1D,
    ST_DATAGRAM = 8'h22,
    ST_RAW_FRAMES = 8'h42
  } sst_state_type;

endpackage

// *** rtl/sst_flag_bits.sv ***
// Sticky event flags, cleared by writing ones.
// Assumes set and clear pulses on the same clock.
`timescale 1ns/1ps
module sst_flag_bits #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Flag events
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  // Set wins over a clear in the same cycle, so no event is lost
  assign flags_d = (flags_q & ~clr_bits) | set_bits;

  always_ff @(posedge clk)
  begin
    if (rst)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    (set_bits[0] && clr_bits[0]) |=> flags_q[0])
    else $error("Flag set lost against a clear");

endmodule // sst_flag_bits

// *** bench/sst_peer.sv ***
// Remote peer model: answers our SYN, SYN/ACK and FIN after a lag.
// Assumes the tracker clock; strobes change at the falling edge.
`timescale 1ns/1ps
module sst_peer (
  // Clock
  input wire logic clk,
  // Requests from the tracker
  input wire logic tx_syn,
  input wire logic tx_synack,
  input wire logic tx_fin,
  // Behaviour set by the bench
  input wire logic answer,
  input wire logic [7:0] lag,
  // Segments towards the tracker
  output logic rx_syn,
  output logic rx_synack,
  output logic rx_fin,
  output logic rx_finack,
  output logic rx_rst,
  output logic synack_done
);
  logic [5:0] seg = 6'h00;
  assign rx_syn = seg[0];
  assign rx_synack = seg[1];
  assign rx_fin = seg[2];
  assign rx_finack = seg[3];
  assign rx_rst = seg[4];
  assign synack_done = seg[5];

  // ---------------------------------------------------------------
  // One-cycle segment strobe
  // ---------------------------------------------------------------
  task automatic pulse(input int i, input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    seg[i] = 1'b1;
    @(negedge clk);
    seg[i] = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Automatic answers
  // ---------------------------------------------------------------
  // A silent peer never answers, so the bench can force timeouts
  always @(posedge clk)
  begin
    if (answer && tx_syn)
      fork
        pulse(1, int'(lag));
      join_none
    if (answer && tx_synack)
      fork
        pulse(5, int'(lag));
      join_none
    if (answer && tx_fin)
      fork
        pulse(3, int'(lag));
      join_none
  end
endmodule // sst_peer

// *** bench/socket_state_tracker_bench.sv ***
// Bench for the socket state tracker with a peer model.
// Assumes linger shortened to 4 cycles; expiry comes from the bench.
`timescale 1ns/1ps
module socket_state_tracker_bench;
  import sst_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic expiry = 1'b0;
  logic answer = 1'b1;
  logic [7:0] lag = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, state;
  logic [15:0] port;
  logic syn, synack, fin, finack, seg_rst, sa_done, t_syn, t_synack, t_fin, allowed;
  logic [EVT_WIDTH-1:0] flags;
  int errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;

  sst_tracker #(.SOCKET_ID(0), .LINGER_CYCLES(4)) dut (.clk(clk), .rst(rst),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .rx_syn(syn), .rx_synack(synack), .rx_fin(fin),
    .rx_finack(finack), .rx_rst(seg_rst), .synack_done(sa_done),
    .tcp_retry_expiry(expiry), .tx_syn(t_syn), .tx_synack(t_synack), .tx_fin(t_fin),
    .socket_state(state), .source_port(port), .transfer_allowed(allowed),
    .socket_event_flags(flags));
  sst_peer peer (.clk(clk), .tx_syn(t_syn), .tx_synack(t_synack), .tx_fin(t_fin),
    .answer(answer), .lag(lag), .rx_syn(syn), .rx_synack(synack), .rx_fin(fin),
    .rx_finack(finack), .rx_rst(seg_rst), .synack_done(sa_done));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic wait_st(input logic [7:0] exp);
    int n;
    n = 0;
    while (state !== exp && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk("socket_state", {8'h00, exp}, {8'h00, state});
    if (state !== exp)
      test_done();
  endtask
  task automatic expire();
    @(negedge clk);
    expiry = 1'b1;
    @(negedge clk);
    expiry = 1'b0;
  endtask
  task automatic tcp_open();
    wr(OFF_MODE, {4'h0, PROTO_TCP});
    wr(OFF_COMMAND, CMD_OPEN);
    wait_st(ST_TCP_OPENED);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    chk("state", 16'h0000, {8'h00, state});
    chk("port", RST_PORT, port);
    wr(OFF_STATE, 8'h5A);
    rd_chk("state reg", OFF_STATE, 8'h00);
    rd_chk("unmapped", 8'h3F, 8'h00);
    wr(OFF_PORT_HI, 8'h13);
    wr(OFF_PORT_LO, 8'h88);
    rd_chk("port hi", OFF_PORT_HI, 8'h13);
    rd_chk("port lo", OFF_PORT_LO, 8'h88);
    chk("port", 16'h1388, port);
  endtask
  task automatic t_opens();
    logic [3:0] pr [3] = '{PROTO_TCP, PROTO_UDP, PROTO_RAW};
    logic [7:0] ex [3] = '{8'h13, 8'h22, 8'h42};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_MODE, {4'h0, pr[i]});
      wr(OFF_COMMAND, CMD_OPEN);
      wait_st(ex[i]);
      chk("allowed", {15'h0000, i > 0}, {15'h0000, allowed});
      wr(OFF_COMMAND, (i == 1) ? CMD_GRACEFUL : CMD_CLOSE);
      chk("released", 16'h0000, {8'h00, state});
    end
  endtask
  task automatic t_client();
    lag = 8'h06;
    tcp_open();
    wr(OFF_COMMAND, CMD_CONNECT);
    chk("tx_syn", 16'h0001, {15'h0000, t_syn});
    wait_st(ST_REQUEST_SENT);
    wait_st(ST_CONNECTED);
    chk("flags", 16'h0001, {11'h000, flags});
    chk("allowed", 16'h0001, {15'h0000, allowed});
    rd_chk("events", OFF_EVENTS, 8'h01);
    wr(OFF_EVENTS, 8'h01);
    rd_chk("events", OFF_EVENTS, 8'h00);
    wr(OFF_COMMAND, CMD_GRACEFUL);
    chk("tx_fin", 16'h0001, {15'h0000, t_fin});
    wait_st(ST_FINISHING);
    wait_st(ST_LINGER);
    wait_st(ST_RELEASED);
    wr(OFF_EVENTS, 8'h1F);
  endtask
  task automatic t_server();
    lag = 8'h00;
    tcp_open();
    wr(OFF_COMMAND, CMD_LISTEN);
    wait_st(ST_AWAITING_PEER);
    peer.pulse(0, 0);
    wait_st(ST_REQUEST_RECEIVED);
    wait_st(ST_CONNECTED);
    peer.pulse(2, 0);
    wait_st(ST_HALF_CLOSED);
    chk("allowed", 16'h0001, {15'h0000, allowed});
    wr(OFF_COMMAND, CMD_GRACEFUL);
    wait_st(ST_FINAL_ACK_WAIT);
    wait_st(ST_RELEASED);
    rd_chk("events", OFF_EVENTS, 8'h03);
    wr(OFF_EVENTS, 8'h1F);
  endtask
  task automatic t_timeouts();
    answer = 1'b0;
    tcp_open();
    expire();
    chk("state", 16'h0013, {8'h00, state});
    wr(OFF_COMMAND, CMD_CONNECT);
    repeat (10) @(negedge clk);
    chk("state", 16'h0015, {8'h00, state});
    expire();
    wait_st(ST_RELEASED);
    rd_chk("events", OFF_EVENTS, 8'h08);
    wr(OFF_EVENTS, 8'h08);
    tcp_open();
    wr(OFF_COMMAND, CMD_LISTEN);
    wait_st(ST_AWAITING_PEER);
    expire();
    wait_st(ST_RELEASED);
    rd_chk("events", OFF_EVENTS, 8'h08);
    wr(OFF_EVENTS, 8'h08);
    // Silent peer: reach final-ack wait by hand, then let it expire
    tcp_open();
    wr(OFF_COMMAND, CMD_CONNECT);
    peer.pulse(1, 0);
    peer.pulse(2, 0);
    wait_st(ST_HALF_CLOSED);
    wr(OFF_COMMAND, CMD_GRACEFUL);
    wait_st(ST_FINAL_ACK_WAIT);
    expire();
    wait_st(ST_RELEASED);
    rd_chk("events", OFF_EVENTS, 8'h0B);
    wr(OFF_EVENTS, 8'h1F);
    answer = 1'b1;
  endtask
  task automatic t_abort();
    tcp_open();
    wr(OFF_COMMAND, CMD_CONNECT);
    wait_st(ST_CONNECTED);
    peer.pulse(4, 0);
    wait_st(ST_RELEASED);
    tcp_open();
    wr(OFF_COMMAND, CMD_CONNECT);
    wait_st(ST_CONNECTED);
    wr(OFF_COMMAND, CMD_CLOSE);
    chk("released", 16'h0000, {8'h00, state});
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("port", RST_PORT, port);
    rd_chk("events", OFF_EVENTS, 8'h00);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_opens();
    t_client();
    t_server();
    t_timeouts();
    t_abort();
    test_done();
  end
endmodule // socket_state_tracker_bench
